// file: spsc_pin_strap_config.sv
// standalone strap decoder: turns resolved strap levels into chopper,
// current and diagnostic settings, and runs standstill power-down
// assumes strap pads and step pin are asynchronous to clk_sys_i
`timescale 1ns/1ns
`default_nettype none

module spsc_pin_strap_config
   import spsc_pkg::*;
#(
   parameter int STANDSTILL_CYC = STANDSTILL_CYC_DEF,
   parameter int RAMP_CYC       = RAMP_CYC_DEF,
   parameter int SETTLE_CYC     = STRAP_SETTLE_CYC
)(
   // clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_n_i,
   // pads from the board
   input  wire logic                  standalone_n_i,
   input  wire logic [NUM_STRAPS-1:0] strap_pin_i,
   input  wire logic                  step_pin_i,
   output logic                       strap_pull_up_o,
   // internal driver status
   input  wire logic                  driver_error_i,
   input  wire logic                  index_pos_i,
   // open-drain diagnostics
   output logic                       diag_error_output_o,
   output logic                       diag_error_oe_o,
   output logic                       diag_index_output_o,
   output logic                       diag_index_oe_o,
   // chopper settings
   output logic [3:0]                 off_time_field_o,
   output logic [3:0]                 hysteresis_end_field_o,
   output logic [1:0]                 blank_time_select_o,
   output logic [3:0]                 microstep_res_o,
   output logic                       interpolate_o,
   output logic                       pwm_mode_en_o,
   output logic [31:0]                voltage_pwm_config_o,
   // current settings
   output logic                       internal_rsense_o,
   output logic                       current_scale_analog_o,
   output logic                       driver_enable_o,
   output logic [4:0]                 run_current_o,
   output logic [4:0]                 hold_current_o,
   output logic [3:0]                 hold_ramp_delay_o,
   output logic [4:0]                 actual_current_o,
   output logic                       standstill_o
);
   localparam int RAMP_STEPS    = int'(CUR_FULL) - int'(HOLD_REDUCED);
   localparam int RAMP_STEP_CYC = (RAMP_CYC / RAMP_STEPS > 0) ? RAMP_CYC / RAMP_STEPS : 1;
   spsc_strap_if lvl ();
   logic        sa_sync1, sa_sync2, step_sync1, step_sync2, step_prev;
   logic        active, step_edge, pd_mode;
   logic [31:0] idle_cnt;
   logic [31:0] ramp_cnt;
   spsc_strap_t s_ena;
   ////////////////////////////////////////////////////////////////
   spsc_strap_detect #(
      .SETTLE_CYC (SETTLE_CYC)
   ) u_detect (
      .clk_sys_i       (clk_sys_i),
      .rst_n_i         (rst_n_i),
      .strap_pin_i     (strap_pin_i),
      .strap_pull_up_o (strap_pull_up_o),
      .lvl             (lvl.det)
   );

   // mode and step pins are asynchronous: two flops each
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sa_sync1   <= 1'b1;
         sa_sync2   <= 1'b1;
         step_sync1 <= 1'b0;
         step_sync2 <= 1'b0;
         step_prev  <= 1'b0;
      end else begin
         sa_sync1   <= standalone_n_i;
         sa_sync2   <= sa_sync1;
         step_sync1 <= step_pin_i;
         step_sync2 <= step_sync1;
         step_prev  <= step_sync2;
      end
   end

   assign active    = !sa_sync2 && lvl.levels_valid;
   assign step_edge = step_sync2 && !step_prev;
   assign s_ena     = lvl.strap_level[STRAP_ENABLE];
   assign pd_mode   = active && s_ena == STRAP_LEFT_OPEN;

   ////////////////////////////////////////////////////////////////
   // chopper timing fields; pwm word is never fed by these straps
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         off_time_field_o       <= OFF_TIME_FIELD_POR;
         hysteresis_end_field_o <= HYSTERESIS_END_FIELD_POR;
         blank_time_select_o    <= TBL_POR;
         voltage_pwm_config_o   <= PWM_CONFIG_POR;
      end else begin
         voltage_pwm_config_o <= PWM_CONFIG_POR;
         if (!active) begin
            off_time_field_o       <= OFF_TIME_FIELD_POR;
            hysteresis_end_field_o <= HYSTERESIS_END_FIELD_POR;
            blank_time_select_o    <= TBL_POR;
         end else begin
            case (lvl.strap_level[STRAP_OFF_TIME])
               STRAP_TIED_GND: off_time_field_o <= OFF_TIME_FIELD_GND;
               STRAP_TIED_VCC: off_time_field_o <= OFF_TIME_FIELD_VCC;
               default:        off_time_field_o <= OFF_TIME_FIELD_OPEN;
            endcase
            case (lvl.strap_level[STRAP_HYST])
               STRAP_TIED_GND: hysteresis_end_field_o <= HYSTERESIS_END_FIELD_GND;
               STRAP_TIED_VCC: hysteresis_end_field_o <= HYSTERESIS_END_FIELD_VCC;
               default:        hysteresis_end_field_o <= HYSTERESIS_END_FIELD_OPEN;
            endcase
            case (lvl.strap_level[STRAP_BLANK])
               STRAP_TIED_GND: blank_time_select_o <= TBL_GND;
               STRAP_TIED_VCC: blank_time_select_o <= TBL_VCC;
               default:        blank_time_select_o <= TBL_OPEN;
            endcase
         end
      end
   end
   // microstep table, re-evaluated every cycle so live changes take effect
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         microstep_res_o <= MRES_POR;
         interpolate_o   <= 1'b0;
         pwm_mode_en_o   <= 1'b0;
      end else if (!active) begin
         microstep_res_o <= MRES_POR;
         interpolate_o   <= 1'b0;
         pwm_mode_en_o   <= 1'b0;
      end else begin
         pwm_mode_en_o <= lvl.strap_level[STRAP_USTEP_B] == STRAP_LEFT_OPEN &&
                          lvl.strap_level[STRAP_USTEP_A] != STRAP_TIED_GND;
         case ({lvl.strap_level[STRAP_USTEP_B], lvl.strap_level[STRAP_USTEP_A]})
            {STRAP_TIED_GND, STRAP_TIED_GND}: begin
               microstep_res_o <= MRES_FULL;
               interpolate_o   <= 1'b0;
            end
            {STRAP_TIED_GND, STRAP_TIED_VCC}: begin
               microstep_res_o <= MRES_HALF;
               interpolate_o   <= 1'b0;
            end
            {STRAP_TIED_GND, STRAP_LEFT_OPEN}: begin
               microstep_res_o <= MRES_HALF;
               interpolate_o   <= 1'b1;
            end
            {STRAP_TIED_VCC, STRAP_TIED_GND}: begin
               microstep_res_o <= MRES_QTR;
               interpolate_o   <= 1'b0;
            end
            {STRAP_TIED_VCC, STRAP_TIED_VCC}: begin
               microstep_res_o <= MRES_16;
               interpolate_o   <= 1'b0;
            end
            {STRAP_TIED_VCC, STRAP_LEFT_OPEN},
            {STRAP_LEFT_OPEN, STRAP_TIED_VCC}: begin
               microstep_res_o <= MRES_QTR;
               interpolate_o   <= 1'b1;
            end
            default: begin
               microstep_res_o <= MRES_16;
               interpolate_o   <= 1'b1;
            end
         endcase
      end
   end
   // current reference mode; tied low leaves both bits clear
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         internal_rsense_o      <= 1'b0;
         current_scale_analog_o <= 1'b0;
      end else begin
         internal_rsense_o      <= active &&
            lvl.strap_level[STRAP_CUR_MODE] == STRAP_TIED_VCC;
         current_scale_analog_o <= active &&
            lvl.strap_level[STRAP_CUR_MODE] == STRAP_LEFT_OPEN;
      end
   end

   ////////////////////////////////////////////////////////////////
   // enable and static current limits
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         driver_enable_o   <= 1'b0;
         run_current_o     <= RUN_CURRENT_POR;
         hold_current_o    <= HOLD_CURRENT_POR;
         hold_ramp_delay_o <= HDLY_POR;
      end else if (!active) begin
         driver_enable_o   <= 1'b0;
         run_current_o     <= RUN_CURRENT_POR;
         hold_current_o    <= HOLD_CURRENT_POR;
         hold_ramp_delay_o <= HDLY_POR;
      end else begin
         driver_enable_o   <= s_ena != STRAP_TIED_VCC;
         run_current_o     <= CUR_FULL;
         hold_current_o    <= (s_ena == STRAP_LEFT_OPEN) ? HOLD_REDUCED : CUR_FULL;
         hold_ramp_delay_o <= (s_ena == STRAP_LEFT_OPEN) ? HOLD_DELAY_SB : HDLY_POR;
      end
   end
   // idle counter: standstill once no step arrived for the full window
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_cnt     <= '0;
         standstill_o <= 1'b0;
      end else if (!pd_mode || step_edge) begin
         idle_cnt     <= '0;
         standstill_o <= 1'b0;
      end else if (idle_cnt != 32'(STANDSTILL_CYC)) begin
         idle_cnt <= idle_cnt + 32'h0000_0001;
      end else begin
         standstill_o <= 1'b1;
      end
   end
   // linear ramp toward hold current, one unit per step interval
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ramp_cnt         <= '0;
         actual_current_o <= 5'h00;
      end else if (!active || s_ena == STRAP_TIED_VCC) begin
         ramp_cnt         <= '0;
         actual_current_o <= 5'h00;
      end else if (!standstill_o) begin
         ramp_cnt         <= '0;
         actual_current_o <= CUR_FULL;
      end else if (ramp_cnt != 32'(RAMP_STEP_CYC - 1)) begin
         ramp_cnt <= ramp_cnt + 32'h0000_0001;
      end else begin
         ramp_cnt <= '0;
         if (actual_current_o > HOLD_REDUCED)
            actual_current_o <= actual_current_o - 5'h01;
      end
   end
   // open-drain diagnostics: pull low while the condition holds
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         diag_error_output_o <= 1'b0;
         diag_error_oe_o     <= 1'b0;
         diag_index_output_o <= 1'b0;
         diag_index_oe_o     <= 1'b0;
      end else begin
         diag_error_output_o <= 1'b0;
         diag_index_output_o <= 1'b0;
         diag_error_oe_o     <= active && driver_error_i;
         diag_index_oe_o     <= active && index_pos_i;
      end
   end

   ////////////////////////////////////////////////////////////////
   hysteresis_end_field_map_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      active && lvl.strap_level[STRAP_HYST] == STRAP_TIED_VCC |=> hysteresis_end_field_o == 4'hb)
      else $error("hysteresis end wrong for supply strap");
   blank_map_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      active && lvl.strap_level[STRAP_BLANK] == STRAP_LEFT_OPEN |=> blank_time_select_o == 2'h2)
      else $error("blank time wrong for open strap");
   off_time_field_map_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      active && lvl.strap_level[STRAP_OFF_TIME] == STRAP_TIED_GND |=> off_time_field_o == 4'h4)
      else $error("off time wrong for ground strap");
   cur_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      internal_rsense_o |-> !current_scale_analog_o && $past(active))
      else $error("current mode bits inconsistent");
   drv_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      active && s_ena == STRAP_TIED_VCC |=> !driver_enable_o && actual_current_o == 5'h00)
      else $error("driver not disabled by supply strap");
   stand_wait_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(standstill_o) |-> $past(idle_cnt) == 32'(STANDSTILL_CYC))
      else $error("standstill flagged early");
   ramp_floor_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pd_mode && $past(pd_mode) && $past(actual_current_o) != 5'h00
      |-> actual_current_o >= HOLD_REDUCED)
      else $error("current ramped below hold level");
   pwm_word_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      voltage_pwm_config_o == 32'h0005_0480)
      else $error("voltage pwm word changed");
   fallback_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !active |=> !driver_enable_o && off_time_field_o == OFF_TIME_FIELD_POR && !pwm_mode_en_o)
      else $error("settings not at defaults outside standalone");
   diag_od_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      diag_error_oe_o |-> !diag_error_output_o && $past(driver_error_i))
      else $error("error indicator driven without cause");
endmodule : spsc_pin_strap_config
`default_nettype wire

// file: spsc_pkg.sv
// constants, field layouts and types for the standalone pin-strap decoder
// assumes a 125 MHz system clock; shared by the detector and the decoder
package spsc_pkg;

   // clock and strap probing timing
   localparam int CLK_PERIOD_NS   = 8;
   localparam int STRAP_SETTLE_NS = 1000;
   localparam int STRAP_SETTLE_CYC =
      (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;   // least time rounds up

   // standstill detection and current ramp defaults, in clock cycles
   localparam int STANDSTILL_CYC_DEF = 1000000;
   localparam int RAMP_CYC_DEF       = 44000000;

   // strap pin indices
   localparam int NUM_STRAPS      = 7;
   localparam int STRAP_OFF_TIME  = 0;
   localparam int STRAP_USTEP_A   = 1;
   localparam int STRAP_USTEP_B   = 2;
   localparam int STRAP_CUR_MODE  = 3;
   localparam int STRAP_HYST      = 4;
   localparam int STRAP_BLANK     = 5;
   localparam int STRAP_ENABLE    = 6;

   // off-time field values
   localparam logic [3:0] OFF_TIME_FIELD_GND  = 4'h4;
   localparam logic [3:0] OFF_TIME_FIELD_VCC  = 4'h7;
   localparam logic [3:0] OFF_TIME_FIELD_OPEN = 4'ha;
   // hysteresis end field values
   localparam logic [3:0] HYSTERESIS_END_FIELD_GND  = 4'h7;
   localparam logic [3:0] HYSTERESIS_END_FIELD_VCC  = 4'hb;
   localparam logic [3:0] HYSTERESIS_END_FIELD_OPEN = 4'hf;
   // blank time select values (16, 24, 36 clocks)
   localparam logic [1:0] TBL_GND   = 2'h0;
   localparam logic [1:0] TBL_VCC   = 2'h1;
   localparam logic [1:0] TBL_OPEN  = 2'h2;
   // current settings
   localparam logic [4:0] CUR_FULL      = 5'h1f;
   localparam logic [4:0] HOLD_REDUCED  = 5'h0b;
   localparam logic [3:0] HOLD_DELAY_SB = 4'h8;
   // microstep resolution codes
   localparam logic [3:0] MRES_FULL = 4'h8;
   localparam logic [3:0] MRES_HALF = 4'h7;
   localparam logic [3:0] MRES_QTR  = 4'h6;
   localparam logic [3:0] MRES_16   = 4'h4;
   // voltage pwm chopper power-on configuration
   localparam logic [31:0] PWM_CONFIG_POR = 32'h0005_0480;

   // power-on defaults used outside standalone mode
   localparam logic [3:0] OFF_TIME_FIELD_POR  = 4'h0;
   localparam logic [3:0] HYSTERESIS_END_FIELD_POR  = 4'h0;
   localparam logic [1:0] TBL_POR   = 2'h0;
   localparam logic [4:0] RUN_CURRENT_POR  = 5'h00;
   localparam logic [4:0] HOLD_CURRENT_POR = 5'h00;
   localparam logic [3:0] HDLY_POR  = 4'h0;
   localparam logic [3:0] MRES_POR  = 4'h0;

   // resolved level of one strap pin
   typedef enum logic [1:0] {
      STRAP_TIED_GND,
      STRAP_TIED_VCC,
      STRAP_LEFT_OPEN
   } spsc_strap_t;

endpackage : spsc_pkg

// file: spsc_strap_if.sv
// carrier for resolved strap levels between detector and decoder
// assumes both ends on clk_sys_i
`timescale 1ns/1ns
`default_nettype none
interface spsc_strap_if;
   import spsc_pkg::*;
   spsc_strap_t strap_level [NUM_STRAPS];
   logic        levels_valid;
   modport det (output strap_level, output levels_valid);
   modport dec (input strap_level, input levels_valid);
endinterface : spsc_strap_if
`default_nettype wire

// file: spsc_strap_detect.sv
// three-state detector for the strap pins: probes each pin with a weak
// pull-down then a weak pull-up and compares the two sampled levels
// assumes the pad pull direction follows strap_pull_up_o
`timescale 1ns/1ns
`default_nettype none
module spsc_strap_detect
   import spsc_pkg::*;
#(
   parameter int SETTLE_CYC = STRAP_SETTLE_CYC
)(
   // clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_n_i,
   // strap pads
   input  wire logic [NUM_STRAPS-1:0]  strap_pin_i,
   output logic                        strap_pull_up_o,
   // resolved levels
   spsc_strap_if.det                   lvl
);

   typedef enum logic {PROBE_LOW, PROBE_HIGH} spsc_probe_t;

   logic [NUM_STRAPS-1:0] sync1;
   logic [NUM_STRAPS-1:0] sync2;
   logic [NUM_STRAPS-1:0] seen_low;
   logic [15:0]           settle_cnt;
   spsc_probe_t           probe;
   logic                  sample;

   assign sample = (settle_cnt == 16'(SETTLE_CYC - 1));

   ////////////////////////////////////////////////////////////////
   // pins are asynchronous: two flops before any use
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= strap_pin_i;
         sync2 <= sync1;
      end
   end

   // probe sequencer runs forever so live strap changes are followed
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         probe           <= PROBE_LOW;
         settle_cnt      <= '0;
         strap_pull_up_o <= 1'b0;
      end else if (sample) begin
         settle_cnt <= '0;
         case (probe)
            PROBE_LOW: begin
               probe           <= PROBE_HIGH;
               strap_pull_up_o <= 1'b1;
            end
            PROBE_HIGH: begin
               probe           <= PROBE_LOW;
               strap_pull_up_o <= 1'b0;
            end
            default: probe <= PROBE_LOW;
         endcase
      end else begin
         settle_cnt <= settle_cnt + 16'h0001;
      end
   end

   // per-pin classification: equal samples mean tied, differing mean open
   generate
      for (genvar i = 0; i < NUM_STRAPS; i++) begin : g_pin
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               seen_low[i]       <= 1'b0;
               lvl.strap_level[i] <= STRAP_TIED_GND;
            end else if (sample && probe == PROBE_LOW) begin
               seen_low[i] <= sync2[i];
            end else if (sample) begin
               if (seen_low[i] != sync2[i])
                  lvl.strap_level[i] <= STRAP_LEFT_OPEN;
               else if (sync2[i])
                  lvl.strap_level[i] <= STRAP_TIED_VCC;
               else
                  lvl.strap_level[i] <= STRAP_TIED_GND;
            end
         end
      end
   endgenerate

   // levels are trusted only after one full low/high probe pair
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i)
         lvl.levels_valid <= 1'b0;
      else if (sample && probe == PROBE_HIGH)
         lvl.levels_valid <= 1'b1;
   end

   pull_alt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      sample |=> strap_pull_up_o != $past(strap_pull_up_o))
      else $error("pull direction did not alternate");

endmodule : spsc_strap_detect
`default_nettype wire

// file: spsc_strap_pads.sv
// board-side model of the seven strap pads, each tied low, tied high or open
// assumes the decoder's weak pull direction is the only thing an open pad sees
`timescale 1ns/1ns
`default_nettype none
module spsc_strap_pads (
   // weak pull from the decoder
   input  wire logic            pull_up_i,
   // per pad: 0 tied low, 1 tied high, 2 open
   input  wire logic [6:0][1:0] cfg_i,
   // pad levels
   output logic      [6:0]      pin_o
);
   // tied pads ignore the pull, open pads follow it
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pin_o[i] = (cfg_i[i] == 2'h2) ? pull_up_i : cfg_i[i][0];
      end
   end
endmodule : spsc_strap_pads
`default_nettype wire

// file: testbench.sv
// self-checking bench for the strap decoder with a queue-free reference model
// assumes short settle, standstill and ramp parameters for a quick run
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import spsc_pkg::*;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, standalone_n_i = 1'b0, step_pin_i = 1'b0;
   logic driver_error_i = 1'b0, index_pos_i = 1'b0, err_prev = 1'b0, idx_prev = 1'b0;
   logic pull, stepping = 1'b0, chk_diag = 1'b0;
   logic [6:0] pins;
   logic [6:0][1:0] c = '0;
   logic [2:0] cnt = 3'h0;
   logic de_oe, di_oe, de_o, di_o, irs, isa, en, ssl, itp, pwm;
   logic [3:0] off_time_field, hysteresis_end_field, mres, hdly;
   logic [1:0] blank_time_select;
   logic [4:0] run_current, hold_current, iact;
   logic [31:0] pwmw;
   int mismatches = 0, cmp_count = 0, seed = 32'h39cc;
   int mr[9] = '{8, 7, 7, 6, 4, 6, 4, 6, 4};
   int ip[9] = '{0, 0, 1, 0, 0, 1, 1, 1, 1};
   always #4 clk_sys_i = ~clk_sys_i;
   spsc_strap_pads PADS (.pull_up_i(pull), .cfg_i(c), .pin_o(pins));
   spsc_pin_strap_config #(.STANDSTILL_CYC(50), .RAMP_CYC(200), .SETTLE_CYC(8)) DUT (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .standalone_n_i(standalone_n_i),
      .strap_pin_i(pins), .step_pin_i(step_pin_i), .strap_pull_up_o(pull),
      .driver_error_i(driver_error_i), .index_pos_i(index_pos_i),
      .diag_error_output_o(de_o), .diag_error_oe_o(de_oe), .diag_index_output_o(di_o),
      .diag_index_oe_o(di_oe), .off_time_field_o(off_time_field), .hysteresis_end_field_o(hysteresis_end_field),
      .blank_time_select_o(blank_time_select), .microstep_res_o(mres), .interpolate_o(itp),
      .pwm_mode_en_o(pwm), .voltage_pwm_config_o(pwmw), .internal_rsense_o(irs),
      .current_scale_analog_o(isa), .driver_enable_o(en), .run_current_o(run_current),
      .hold_current_o(hold_current), .hold_ramp_delay_o(hdly), .actual_current_o(iact),
      .standstill_o(ssl));
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] pk(input logic [1:0] s, input int g, v, o);
      return (s == 2'h0) ? g : (s == 2'h1) ? v : o;
   endfunction : pk
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : wt
   // wait n rising edges, then sample on the falling edge where outputs are settled
   task automatic wn(input int n);
      wt(n);
      @(negedge clk_sys_i);
   endtask : wn
   // reference model of every decoded setting for the present strap levels, except run and hold current and hold delay with the enable pad tied high
   task automatic chk_cfg();
      int k;
      k = c[2] * 3 + c[1];
      @(negedge clk_sys_i);
      chk(off_time_field, pk(c[0], 4, 7, 10), "off time");
      chk(hysteresis_end_field, pk(c[4], 7, 11, 15), "hysteresis end");
      chk(blank_time_select, pk(c[5], 0, 1, 2), "blank time");
      chk(irs, c[3] == 2'h1, "rsense select");
      chk(isa, c[3] == 2'h2, "analog scale");
      chk(en, c[6] != 2'h1, "driver enable");
      chk(iact, (c[6] == 2'h1) ? 0 : 31, "actual current");
      if (c[6] != 2'h1) begin
         chk(run_current, 31, "run current");
         chk(hold_current, pk(c[6], 31, 0, 11), "hold current");
         chk(hdly, pk(c[6], 0, 0, 8), "hold delay");
      end
      chk(mres, mr[k], "microstep res");
      chk(itp, ip[k], "interpolation");
      chk(pwm, c[2] == 2'h2 && c[1] != 2'h0, "pwm mode");
      chk(pwmw, 32'h0005_0480, "pwm word");
      chk({de_o, di_o}, 0, "diag values");
      // hand back on a rising edge so the next pad change lands there
      @(posedge clk_sys_i);
   endtask : chk_cfg
   ////////////////////////////////////////////////////////////////////////////
   // step pulses four cycles high, four low, so standstill never triggers
   always @(posedge clk_sys_i) begin
      cnt <= cnt + 3'h1;
      step_pin_i <= stepping & cnt[2];
      driver_error_i <= 1'($random(seed));
      index_pos_i <= 1'($random(seed));
      err_prev <= driver_error_i;
      idx_prev <= index_pos_i;
   end
   // open-drain pull-down follows the status one edge late while active
   always @(negedge clk_sys_i) begin
      if (chk_diag) begin
         chk(de_oe, err_prev, "error oe");
         chk(di_oe, idx_prev, "index oe");
      end
   end
   // watchdog well beyond the expected run length
   initial begin
      #200000;
      mismatches++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      wt(16);
      rst_n_i <= 1'b1;
      stepping <= 1'b1;
      for (int n = 0; n < 24; n++) begin
         for (int i = 0; i < 7; i++) c[i] <= 2'($unsigned($random(seed)) % 3);
         wt(40);
         chk_diag <= 1'b1;
         chk_cfg();
      end
      // standstill: enable pad open, then the controller stops stepping
      c[6] <= 2'h2;
      wt(40);
      chk_cfg();
      stepping <= 1'b0;
      wn(20);
      chk({ssl, iact}, {1'b0, 5'd31}, "before standstill");
      wn(300);
      chk({ssl, iact}, {1'b1, 5'd11}, "after ramp");
      wt(1);
      stepping <= 1'b1;
      wn(14);
      chk({ssl, iact}, {1'b0, 5'd31}, "step wakes");
      // leaving standalone mode falls back to power-on defaults
      wt(1);
      chk_diag <= 1'b0;
      standalone_n_i <= 1'b1;
      wn(10);
      chk({en, run_current, hold_current, hdly, off_time_field, hysteresis_end_field, blank_time_select}, 0, "defaults");
      chk({mres, itp, pwm, irs, isa, iact, ssl, de_oe, di_oe}, 0, "more defaults");
      chk(pwmw, 32'h0005_0480, "pwm word kept");
      close_out();
   end
endmodule : testbench
`default_nettype wire
